// ---- logic/clkdiv_top.sv ----
// Chosen here: register access over AHB-Lite.
`timescale 1ns/10ps
module clkdiv_top #(
    parameter int ADDR_W = 32
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    input  wire logic              sync_n,
    input  wire logic              osc_in,
    input  wire logic              clk_in,
    output logic                   pair_a_out_first,
    output logic                   pair_a_out_second,
    output logic                   pair_b_out_first,
    output logic                   pair_b_out_second,
    output logic [1:0]             duty_fix_disable
);
    import clkdiv_pkg::*;

    // The range check on haddr needs at least one bit above the index
    if (ADDR_W < IDX_W + 3 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W out of range");
    end

    logic [NUM_DIV-1:0][7:0] cyc_ff;
    logic [NUM_DIV-1:0][7:0] ctl_ff;
    logic [NUM_DIV-1:0][1:0] route_ff;
    logic [1:0]              src_sel_ff;
    logic [NUM_DIV-1:0]      pair_ff;
    logic [NUM_DIV-1:0]      div_lvl;
    logic [NUM_DIV-1:0]      div_run;
    logic [1:0]              sync_sh_ff;
    logic [1:0]              osc_sh_ff;
    logic [1:0]              clkin_sh_ff;
    logic                    dp_write_ff;
    logic                    rd_pend_ff;
    logic [IDX_W-1:0]        dp_idx_ff;
    logic                    hreadyout_ff;
    logic [31:0]             hrdata_ff;
    logic [7:0]              rd_div;
    logic [31:0]             nxt_rdata;
    logic [NUM_DIV-1:0]      pair_n_ff;

    // Pins from outside: two flops before anything looks at them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_sh_ff  <= 2'h3;
            osc_sh_ff   <= 2'h0;
            clkin_sh_ff <= 2'h0;
        end else begin
            sync_sh_ff  <= {sync_sh_ff[0], sync_n};
            osc_sh_ff   <= {osc_sh_ff[0], osc_in};
            clkin_sh_ff <= {clkin_sh_ff[0], clk_in};
        end
    end

    wire sync_active = ~sync_sh_ff[1];
    wire osc_s       = osc_sh_ff[1];
    wire clkin_s     = clkin_sh_ff[1];

    // Bus address phase
    wire              ap_valid = hsel && hready && htrans[1];
    wire              ap_range = (haddr[ADDR_W-1:IDX_W+2] == '0);
    wire [IDX_W-1:0]  ap_idx   = ap_range ? haddr[IDX_W+1:2] : '1;
    wire              wr_en    = dp_write_ff;
    wire [7:0]        wbyte    = hwdata[7:0];

    // Reads take one wait state so the data come from a register and see any write just ended
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write_ff  <= 1'b0;
            rd_pend_ff   <= 1'b0;
            dp_idx_ff    <= '0;
            hreadyout_ff <= 1'b1;
            hrdata_ff    <= 32'h0000_0000;
        end else begin
            dp_write_ff  <= ap_valid && hwrite;
            rd_pend_ff   <= ap_valid && !hwrite;
            dp_idx_ff    <= ap_valid ? ap_idx : dp_idx_ff;
            hreadyout_ff <= !(ap_valid && !hwrite);
            hrdata_ff    <= rd_pend_ff ? nxt_rdata : hrdata_ff;
        end
    end

    assign hreadyout = hreadyout_ff;
    assign hresp     = HRESP_OKAY;
    assign hrdata    = hrdata_ff;

    logic [NUM_DIV-1:0][7:0] rd_part;

    genvar c;
    generate
        for (c = 0; c < NUM_DIV; c++) begin : g_ch
            div_cfg_s cfg;
            wire      hit_cyc   = (dp_idx_ff == CYC_IDX[c]);
            wire      hit_ctl   = (dp_idx_ff == CTL_IDX[c]);
            wire      hit_route = (dp_idx_ff == ROUTE_IDX[c]);
            wire      direct    = route_ff[c][ROUTE_DIRECT];
            wire      use_osc   = direct && (src_sel_ff == SRC_OSC);
            wire      use_clkin = direct && (src_sel_ff == SRC_CLKIN);
            wire      nxt_pair  = use_osc ? osc_s : (use_clkin ? clkin_s : div_lvl[c]);

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cyc_ff[c]   <= CYC_RST[c];
                    ctl_ff[c]   <= CTL_RST[c];
                    route_ff[c] <= ROUTE_RST;
                    pair_ff[c]  <= 1'b0;
                    pair_n_ff[c] <= 1'b1;
                end else begin
                    cyc_ff[c]   <= (wr_en && hit_cyc) ? wbyte : cyc_ff[c];
                    ctl_ff[c]   <= (wr_en && hit_ctl) ? wbyte : ctl_ff[c];
                    route_ff[c] <= (wr_en && hit_route) ? wbyte[1:0] : route_ff[c];
                    pair_ff[c]  <= nxt_pair;
                    pair_n_ff[c] <= ~nxt_pair;
                end
            end

            assign cfg.bypass     = ctl_ff[c][CTL_BYPASS];
            assign cfg.nosync     = ctl_ff[c][CTL_NOSYNC];
            assign cfg.force_high = ctl_ff[c][CTL_FORCE];
            assign cfg.start_high = ctl_ff[c][CTL_START];
            assign cfg.phase      = ctl_ff[c][CTL_PHASE_LSB+:4];
            assign cfg.low_cnt    = cyc_ff[c][CYC_LOW_LSB+:4];
            assign cfg.high_cnt   = cyc_ff[c][CYC_HIGH_LSB+:4];

            div_core u_div (
                .hclk        (hclk),
                .hresetn     (hresetn),
                .cfg         (cfg),
                .sync_active (sync_active),
                .div_out     (div_lvl[c]),
                .running     (div_run[c])
            );

            assign rd_part[c] = (dp_idx_ff == CYC_IDX[c])   ? cyc_ff[c] :
                                (dp_idx_ff == CTL_IDX[c])   ? ctl_ff[c] :
                                (dp_idx_ff == ROUTE_IDX[c]) ? {6'h00, route_ff[c]} : 8'h00;

            route_osc_a: assert property (@(posedge hclk) disable iff (!hresetn)
                (use_osc ##1 use_osc) |-> pair_ff[c] == $past(osc_s)) else $error("oscillator route wrong");

            route_div_a: assert property (@(posedge hclk) disable iff (!hresetn)
                (!direct || src_sel_ff == SRC_DIV) ##1 (!direct || src_sel_ff == SRC_DIV)
                |-> pair_ff[c] == $past(div_lvl[c])) else $error("divider route wrong");
        end
    endgenerate

    always_comb begin
        rd_div = 8'h00;
        for (int i = 0; i < NUM_DIV; i++) begin
            rd_div = rd_div | rd_part[i];
        end
    end

    always_comb begin
        if (dp_idx_ff == SRC_SEL_IDX) begin
            nxt_rdata = {30'h0000_0000, src_sel_ff};
        end else if (dp_idx_ff == STATUS_IDX) begin
            nxt_rdata = {28'h000_0000, div_run, pair_ff};
        end else begin
            nxt_rdata = {24'h00_0000, rd_div};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_sel_ff <= SRC_RST;
        end else begin
            src_sel_ff <= (wr_en && dp_idx_ff == SRC_SEL_IDX) ? wbyte[1:0] : src_sel_ff;
        end
    end

    // Second leg of each pair is the complement of the first, in its own flop so no gate skews it
    assign pair_a_out_first  = pair_ff[0];
    assign pair_a_out_second = pair_n_ff[0];
    assign pair_b_out_first  = pair_ff[1];
    assign pair_b_out_second = pair_n_ff[1];
    assign duty_fix_disable  = {route_ff[1][ROUTE_DUTYOFF], route_ff[0][ROUTE_DUTYOFF]};

    reset_values_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> cyc_ff[0] == 8'h00 && cyc_ff[1] == 8'hBB) else $error("cycle field reset wrong");

    reset_bypass_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> ctl_ff[0][CTL_BYPASS] && !ctl_ff[1][CTL_BYPASS]) else $error("bypass reset wrong");

    read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (ap_valid && !hwrite) |=> !hreadyout ##1 hreadyout) else $error("read timing wrong");

endmodule

// ---- logic/clkdiv_pkg.sv ----
package clkdiv_pkg;

    localparam int NUM_DIV = 2;
    localparam int IDX_W   = 10;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] DIV0_CYC_IDX    = 10'h190;
    localparam logic [IDX_W-1:0] DIV0_CTL_IDX    = 10'h191;
    localparam logic [IDX_W-1:0] DIV0_ROUTE_IDX  = 10'h192;
    localparam logic [IDX_W-1:0] DIV1_CYC_IDX    = 10'h193;
    localparam logic [IDX_W-1:0] DIV1_CTL_IDX    = 10'h194;
    localparam logic [IDX_W-1:0] DIV1_ROUTE_IDX  = 10'h195;
    localparam logic [IDX_W-1:0] STATUS_IDX      = 10'h19F;
    localparam logic [IDX_W-1:0] SRC_SEL_IDX     = 10'h1E1;
    localparam logic [NUM_DIV-1:0][IDX_W-1:0] CYC_IDX   = {DIV1_CYC_IDX, DIV0_CYC_IDX};
    localparam logic [NUM_DIV-1:0][IDX_W-1:0] CTL_IDX   = {DIV1_CTL_IDX, DIV0_CTL_IDX};
    localparam logic [NUM_DIV-1:0][IDX_W-1:0] ROUTE_IDX = {DIV1_ROUTE_IDX, DIV0_ROUTE_IDX};

    // Field positions
    localparam int CYC_LOW_LSB   = 4;
    localparam int CYC_HIGH_LSB  = 0;
    localparam int CTL_BYPASS    = 7;
    localparam int CTL_NOSYNC    = 6;
    localparam int CTL_FORCE     = 5;
    localparam int CTL_START     = 4;
    localparam int CTL_PHASE_LSB = 0;
    localparam int ROUTE_DIRECT  = 1;
    localparam int ROUTE_DUTYOFF = 0;

    // Reset values, channel 1 in the upper element
    localparam logic [NUM_DIV-1:0][7:0] CYC_RST   = {8'hBB, 8'h00};
    localparam logic [NUM_DIV-1:0][7:0] CTL_RST   = {8'h00, 8'h80};
    localparam logic [1:0]              ROUTE_RST = 2'h0;
    localparam logic [1:0]              SRC_RST   = 2'h1;

    // Clock-source select codes
    localparam logic [1:0] SRC_CLKIN = 2'h0;
    localparam logic [1:0] SRC_DIV   = 2'h1;
    localparam logic [1:0] SRC_OSC   = 2'h2;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

    typedef enum logic [1:0] {
        HOLD_ST  = 2'b00,
        DELAY_ST = 2'b01,
        RUN_ST   = 2'b10
    } div_state_e;

    typedef struct packed {
        logic       bypass;
        logic       nosync;
        logic       force_high;
        logic       start_high;
        logic [3:0] phase;
        logic [3:0] low_cnt;
        logic [3:0] high_cnt;
    } div_cfg_s;

endpackage

// ---- logic/div_core.sv ----
`timescale 1ns/10ps
module div_core (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire clkdiv_pkg::div_cfg_s cfg,
    input  wire logic                sync_active,
    output logic                     div_out,
    output logic                     running
);
    import clkdiv_pkg::*;

    div_state_e state_ff, nxt_state;
    div_cfg_s   shad_ff, nxt_shad;
    logic [3:0] cnt_ff, nxt_cnt;
    logic       out_ff, nxt_out;
    logic [4:0] age_ff;
    logic       toggled_ff;

    wire        held   = sync_active && !cfg.nosync;
    wire        forced = cfg.nosync && !cfg.bypass;
    wire [3:0]  lim    = out_ff ? shad_ff.high_cnt : shad_ff.low_cnt;
    wire        wrap   = (cnt_ff == lim);
    wire [3:0]  dly_end = 4'(shad_ff.phase - 4'h1);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_out   = out_ff;
        nxt_shad  = shad_ff;
        if (cfg.bypass) begin
            // Stand-in for the raw input clock: one level per input cycle
            nxt_out   = ~out_ff;
            nxt_state = HOLD_ST;
            nxt_cnt   = 4'h0;
            nxt_shad  = cfg;
        end else if (forced) begin
            nxt_out   = cfg.force_high;
            nxt_state = HOLD_ST;
            nxt_cnt   = 4'h0;
            nxt_shad  = cfg;
        end else if (held) begin
            nxt_out   = cfg.start_high;
            nxt_state = HOLD_ST;
            nxt_cnt   = 4'h0;
            nxt_shad  = cfg;
        end else begin
            case (state_ff)
                HOLD_ST: begin
                    // Fields are taken here and in the bypass, forced and held branches, never in DELAY_ST or RUN_ST, so synced dividers stay aligned
                    nxt_shad  = cfg;
                    nxt_out   = cfg.start_high;
                    nxt_cnt   = 4'h0;
                    nxt_state = (cfg.phase == 4'h0) ? RUN_ST : DELAY_ST;
                end
                DELAY_ST: begin
                    if (cnt_ff == dly_end) begin
                        nxt_state = RUN_ST;
                        nxt_cnt   = 4'h0;
                    end else begin
                        nxt_cnt = 4'(cnt_ff + 4'h1);
                    end
                end
                RUN_ST: begin
                    if (wrap) begin
                        nxt_out = ~out_ff;
                        nxt_cnt = 4'h0;
                    end else begin
                        nxt_cnt = 4'(cnt_ff + 4'h1);
                    end
                end
                default: begin
                    nxt_state = HOLD_ST;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= HOLD_ST;
            cnt_ff   <= 4'h0;
            out_ff   <= 1'b0;
            shad_ff  <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            out_ff   <= nxt_out;
            shad_ff  <= nxt_shad;
        end
    end

    assign div_out = out_ff;
    assign running = (state_ff == RUN_ST);

    // Level age and run history, read only by the checks below
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            age_ff     <= 5'h0;
            toggled_ff <= 1'b0;
        end else begin
            age_ff     <= (nxt_out != out_ff) ? 5'h0 : ((age_ff == 5'h1F) ? age_ff : 5'(age_ff + 5'h1));
            toggled_ff <= (state_ff == RUN_ST) && !cfg.bypass && !forced && !held && (toggled_ff || wrap);
        end
    end

    low_time_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_ff == RUN_ST && toggled_ff && !cfg.bypass && !forced && !held && !out_ff && wrap)
        |-> age_ff == {1'b0, shad_ff.low_cnt}) else $error("low phase length wrong");

    high_time_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_ff == RUN_ST && toggled_ff && !cfg.bypass && !forced && !held && out_ff && wrap)
        |-> age_ff == {1'b0, shad_ff.high_cnt}) else $error("high phase length wrong");

    bypass_pass_a: assert property (@(posedge hclk) disable iff (!hresetn)
        cfg.bypass ##1 cfg.bypass |-> div_out != $past(div_out)) else $error("bypass output not following input");

    force_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (cfg.nosync && !cfg.bypass) |=> div_out == $past(cfg.force_high)) else $error("forced level wrong");

    bypass_wins_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (cfg.bypass && cfg.nosync) ##1 cfg.bypass |-> $changed(div_out)) else $error("force acted in bypass");

    sync_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (held && !cfg.bypass) |=> div_out == $past(cfg.start_high) && state_ff == HOLD_ST)
        else $error("sync did not hold divider");

    delay_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_ff == DELAY_ST) |-> div_out == shad_ff.start_high) else $error("delay level not start level");

endmodule

// ---- dv/output_pair_clock_divider_test.sv ----
`timescale 1ns/10ps
module output_pair_clock_divider_test;
    import clkdiv_pkg::*;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic        hwrite;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        sync_n;
    logic        osc_in;
    logic        clk_in;
    logic        pa1;
    logic        pa2;
    logic        pb1;
    logic        pb2;
    logic [1:0]  duty_fix_disable;
    int          num_errors;
    int          n_tests;
    int          t0;
    int          t5;
    int          lo;
    int          hi;
    logic [31:0] rnd;
    logic [31:0] rd;
    logic [31:0] model [int];
    logic [9:0]  ids [8] = '{DIV0_CYC_IDX, DIV0_CTL_IDX, DIV0_ROUTE_IDX, DIV1_CYC_IDX,
                             DIV1_CTL_IDX, DIV1_ROUTE_IDX, SRC_SEL_IDX, 10'h1A0};
    logic [7:0]  cases [4] = '{8'h00, 8'h37, 8'hF2, 8'hBB};

    clkdiv_top u_dut (
        .hclk              (hclk),
        .hresetn           (hresetn),
        .hsel              (hsel),
        .haddr             (haddr),
        .htrans            (htrans),
        .hwrite            (hwrite),
        .hsize             (hsize),
        .hwdata            (hwdata),
        .hready            (hreadyout),
        .hreadyout         (hreadyout),
        .hresp             (hresp),
        .hrdata            (hrdata),
        .sync_n            (sync_n),
        .osc_in            (osc_in),
        .clk_in            (clk_in),
        .pair_a_out_first  (pa1),
        .pair_a_out_second (pa2),
        .pair_b_out_first  (pb1),
        .pair_b_out_second (pb2),
        .duty_fix_disable  (duty_fix_disable)
    );

    initial hclk = 1'b0;
    always #50 hclk = ~hclk;

    function logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Route and source registers only keep their two low bits
    function logic [31:0] mask(input int idx);
        return (idx == int'(DIV0_ROUTE_IDX) || idx == int'(DIV1_ROUTE_IDX) || idx == int'(SRC_SEL_IDX)) ?
               32'h3 : 32'hFF;
    endfunction

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task final_report;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // Bounded wait for the slave; hreadyout is read before the edge's own updates land
    task wait_rdy;
        int k;
        k = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && k < 50) begin
            k++;
            @(posedge hclk);
        end
        if (k == 50) check("hreadyout", 32'h0, 32'h1);
    endtask

    task bus(input logic wr, input logic [9:0] idx, input logic [31:0] d, output logic [31:0] q);
        // Start right after a rising edge, whatever the caller last waited on
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {20'h0, idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
        check("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
    endtask

    task wr(input logic [9:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d, rd);
        model[int'(idx)] = d & mask(int'(idx));
    endtask

    task rdchk(input logic [9:0] idx);
        bus(1'b0, idx, 32'h0, rd);
        check("register", rd, model.exists(int'(idx)) ? model[int'(idx)] : 32'h0);
    endtask

    task chk_level(input int p, input logic exp);
        @(negedge hclk);
        check("pair_level", {31'h0, p ? pb1 : pa1}, {31'h0, exp});
        check("pair_complement", {31'h0, p ? pb2 : pa2}, {31'h0, ~exp});
    endtask

    task chk_tog(input int p, input logic exp);
        logic a;
        @(negedge hclk);
        a = p ? pb1 : pa1;
        @(negedge hclk);
        check("pair_toggle", {31'h0, a ^ (p ? pb1 : pa1)}, {31'h0, exp});
    endtask

    task sync_pulse;
        sync_n <= 1'b0;
        cyc(5);
        sync_n <= 1'b1;
    endtask

    task lat(output int t);
        t = 0;
        @(negedge hclk);
        while (pb1 !== 1'b1 && t < 200) begin
            t++;
            @(negedge hclk);
        end
    endtask

    // High run then low run of pair B, counted in input cycles
    task measure(output int l, output int h);
        logic prev;
        int   k;
        k = 0;
        @(negedge hclk);
        prev = pb1;
        @(negedge hclk);
        while (!(prev === 1'b0 && pb1 === 1'b1) && k < 100) begin
            prev = pb1;
            k++;
            @(negedge hclk);
        end
        h = 0;
        while (pb1 === 1'b1 && h < 100) begin
            h++;
            @(negedge hclk);
        end
        l = 0;
        while (pb1 === 1'b0 && l < 100) begin
            l++;
            @(negedge hclk);
        end
    endtask

    initial begin
        #(100 * 20000);
        num_errors++;
        final_report();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        sync_n = 1'b1;
        osc_in = 1'b0;
        clk_in = 1'b0;
        num_errors = 0;
        n_tests = 0;
        rnd = 32'h7CF9896A;
        model[int'(DIV0_CYC_IDX)] = 32'h00;
        model[int'(DIV0_CTL_IDX)] = 32'h80;
        model[int'(DIV0_ROUTE_IDX)] = 32'h00;
        model[int'(DIV1_CYC_IDX)] = 32'hBB;
        model[int'(DIV1_CTL_IDX)] = 32'h00;
        model[int'(DIV1_ROUTE_IDX)] = 32'h00;
        model[int'(SRC_SEL_IDX)] = 32'h01;
        cyc(8);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk_tog(0, 1'b1);
        chk_level(1, 1'b0);
        foreach (ids[i]) rdchk(ids[i]);
        for (int i = 0; i < 7; i++) begin
            rnd = lfsr(rnd);
            wr(ids[i], rnd);
            rdchk(ids[i]);
        end
        wr(DIV0_ROUTE_IDX, 32'h0);
        wr(DIV1_ROUTE_IDX, 32'h0);
        foreach (cases[i]) begin
            wr(DIV1_CYC_IDX, {24'h0, cases[i]});
            wr(DIV1_CTL_IDX, 32'h0);
            sync_pulse();
            measure(lo, hi);
            check("high_time", 32'(hi), 32'(cases[i][3:0]) + 32'h1);
            check("low_time", 32'(lo), 32'(cases[i][7:4]) + 32'h1);
        end
        wr(DIV1_CYC_IDX, 32'h11);
        sync_pulse();
        lat(t0);
        wr(DIV1_CTL_IDX, 32'h05);
        sync_pulse();
        lat(t5);
        check("phase_delay", 32'(t5 - t0), 32'h5);
        // Both dividers from one sync with equal settings must stay in step
        wr(DIV0_CYC_IDX, 32'h23);
        wr(DIV0_CTL_IDX, 32'h00);
        wr(DIV1_CYC_IDX, 32'h23);
        wr(DIV1_CTL_IDX, 32'h00);
        sync_pulse();
        cyc(6);
        repeat (8) begin
            @(negedge hclk);
            check("aligned", {31'h0, pa1}, {31'h0, pb1});
        end
        wr(DIV1_CTL_IDX, 32'h10);
        sync_n <= 1'b0;
        cyc(6);
        chk_level(1, 1'b1);
        // Both dividers obey sync here: neither runs, levels are the start levels
        bus(1'b0, STATUS_IDX, 32'h0, rd);
        check("status", rd, 32'h2);
        sync_n <= 1'b1;
        wr(DIV1_CTL_IDX, 32'h60);
        cyc(6);
        chk_level(1, 1'b1);
        wr(DIV1_CTL_IDX, 32'h40);
        cyc(6);
        chk_level(1, 1'b0);
        wr(DIV1_CTL_IDX, 32'hE0);
        cyc(6);
        chk_tog(1, 1'b1);
        for (int p = 0; p < 2; p++) begin
            wr(CTL_IDX[p], 32'h80);
            wr(ROUTE_IDX[p], 32'h2);
            wr(SRC_SEL_IDX, 32'h1);
            cyc(6);
            chk_tog(p, 1'b1);
            wr(SRC_SEL_IDX, 32'h2);
            rnd = lfsr(rnd);
            osc_in <= rnd[0];
            clk_in <= rnd[1];
            cyc(6);
            chk_level(p, rnd[0]);
            wr(SRC_SEL_IDX, 32'h0);
            cyc(6);
            chk_level(p, rnd[1]);
            wr(ROUTE_IDX[p], 32'h1);
            cyc(6);
            chk_tog(p, 1'b1);
            check("duty_fix", {31'h0, duty_fix_disable[p]}, 32'h1);
            wr(ROUTE_IDX[p], 32'h0);
            cyc(2);
            check("duty_fix", {31'h0, duty_fix_disable[p]}, 32'h0);
        end
        final_report();
    end
endmodule
